// ---- rtl/rtcwd_pkg.sv ----
package rtcwd_pkg;
  // register addresses on the host bus
  localparam logic [14:0] A_FLAGS    = 15'h7ff0;
  localparam logic [14:0] A_ALM_SEC  = 15'h7ff2;
  localparam logic [14:0] A_ALM_MIN  = 15'h7ff3;
  localparam logic [14:0] A_ALM_HOUR = 15'h7ff4;
  localparam logic [14:0] A_ALM_DATE = 15'h7ff5;
  localparam logic [14:0] A_IRQ_CTRL = 15'h7ff6;
  localparam logic [14:0] A_WDOG     = 15'h7ff7;
  // event_flags bits
  localparam int FLG_TIMEOUT  = 7;
  localparam int FLG_ALARM    = 6;
  localparam int FLG_SUPPLY   = 5;
  localparam int FLG_BATTERY  = 4;
  localparam int FLG_PERIODIC = 3;
  // interrupt_control bits
  localparam int IC_ALARM_EN  = 7;
  localparam int IC_SUPPLY_EN = 6;
  localparam int IC_BACKUP_EN = 5;
  localparam int IC_PERIOD_EN = 4;
  localparam int IC_RATE_HI   = 3;
  // watchdog_control bits
  localparam int WD_STEER     = 7;
  localparam int WD_MULT_HI   = 6;
  localparam int WD_MULT_LO   = 2;
  localparam int WD_RES_HI    = 1;
  // mask bit of every alarm byte
  localparam int ALM_MASK     = 7;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] WDOG_RST  = 8'h00;
  localparam logic [7:0] ALM_RST   = 8'h00;
  // periodic rate codes
  localparam logic [3:0] RATE_10MS  = 4'h1;
  localparam logic [3:0] RATE_100MS = 4'h2;
  localparam logic [3:0] RATE_BIN   = 4'h3;
  // timing
  localparam int CLK_HZ        = 200000000;
  localparam int BASE_TICK_HZ  = 8192;
  localparam int BASE_TICK_CYC = CLK_HZ / BASE_TICK_HZ;
  localparam int MS_TICK_CYC   = CLK_HZ / 1000;
  localparam int SIXTEENTH_DIV = BASE_TICK_HZ / 16;
  localparam int DECADE_DIV    = 10;
  localparam int CLR_HOLD_NS   = 50;
  localparam logic [3:0] CLR_HOLD_CYC =
    4'((CLR_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000);
  localparam int RESET_HOLD_MS  = 200;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int WARN_LEAD_US   = 100;
  localparam int WARN_LEAD_CYC  = WARN_LEAD_US * (CLK_HZ / 1000000);
  // watchdog states, gray along off-run-hold
  typedef enum logic [1:0] {
    WD_OFF   = 2'b00,
    WD_RUN   = 2'b01,
    WD_HOLD  = 2'b11,
    WD_FIRED = 2'b10
  } rtcwd_wd_e;
endpackage

// ---- rtl/rtcwd_div.sv ----
`timescale 1ns/10ps
// counts enable pulses, ticks once every N of them
module rtcwd_div #(
  parameter int N = 2
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clr,
  input  wire logic i_en,
  output logic      o_tick
);
  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST = W'(N - 1);

  logic [W-1:0] cnt_r;  // pulses seen so far
  wire          at_last = (cnt_r == LAST);

  // clear wins so a restart never leaks a stale tick
  assign o_tick = i_en & at_last & ~i_clr;

  // modulo-n counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_clr) begin
      cnt_r <= '0;
    end else if (i_en) begin
      cnt_r <= at_last ? '0 : cnt_r + W'(1);
    end
  end
endmodule

// ---- rtl/rtcwd_bus.sv ----
`timescale 1ns/10ps
// sram-style pin front end: write strobes and read qualification
module rtcwd_bus (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_b,
  input  wire logic        i_oe_b,
  input  wire logic        i_we_b,
  output logic             o_wr,
  output logic [14:0]      o_wr_addr,
  output logic [7:0]       o_wr_data,
  output logic             o_rd,
  output logic             o_clr,
  output logic             o_clr_held
);
  logic [14:0] addr_q;    // address one cycle back
  logic [7:0]  dq_q;      // data one cycle back
  logic        wlow_q;    // write strobe active last cycle
  logic [3:0]  hold_r;    // cycles flags address held stable

  wire wlow     = ~i_ce_b & ~i_we_b;
  wire wr_end   = wlow_q & ~wlow;
  wire flag_hit = (i_addr == rtcwd_pkg::A_FLAGS);
  wire stable   = flag_hit & (i_addr == addr_q) & o_rd;

  // a read is ce and oe low with we high
  assign o_rd       = ~i_ce_b & ~i_oe_b & i_we_b;
  assign o_clr_held = (hold_r == rtcwd_pkg::CLR_HOLD_CYC);
  // one pulse per read once the address has stood long enough
  assign o_clr = stable &
                 (hold_r == rtcwd_pkg::CLR_HOLD_CYC - 4'h1);

  // pin history, data sampled while the strobe is still low
  always_ff @(posedge i_clk) begin
    addr_q <= i_addr;
    dq_q   <= i_dq;
    wlow_q <= i_rst_b & wlow;
  end

  // write commits on the end of the strobe, as on an sram
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_wr      <= 1'b0;
      o_wr_addr <= 15'h0000;
      o_wr_data <= 8'h00;
    end else begin
      o_wr <= wr_end;
      if (wr_end) begin
        o_wr_addr <= addr_q;
        o_wr_data <= dq_q;
      end
    end
  end

  // hold timer, saturates so one read clears once
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !stable) begin
      hold_r <= 4'h0;
    end else if (!o_clr_held) begin
      hold_r <= hold_r + 4'h1;
    end
  end
endmodule

// ---- rtl/rtcwd_top.sv ----
// Function
// - multiplier bits 6..2, resolution bits 1..0
// - timeout is multiplier times resolution
// - zero multiplier keeps watchdog inactive
// - steer set: reset pulse for hold time
// - watchdog byte cleared during reset pulse
// - steer clear: interrupt until rewrite or fail
// - every timeout sets the timeout flag
// - watchdog write restarts the timeout period
// - supply failure disables the watchdog
// - events set flags, enables gate interrupt
// - flags read clears flags, releases all but the watchdog interrupt
// - clear needs flags address held 50ns
// - rate code selects periodic flag interval
// - alarm compare on each second update
// - alarm bit 7 masks that field
// - backup mode: only alarm with backup enable
// - supply fail flag, interrupt before deselect
// - power-up clears supply fail enable
// - power-up latches weak battery flag
// - power-up clears all interrupt enables
// - reset and interrupt outputs open drain
`timescale 1ns/10ps
module rtcwd_top #(
  parameter int BASE_TICK_CYCLES  = rtcwd_pkg::BASE_TICK_CYC,
  parameter int MS_TICK_CYCLES    = rtcwd_pkg::MS_TICK_CYC,
  parameter int RESET_HOLD_CYCLES = rtcwd_pkg::RESET_HOLD_CYC,
  parameter int WARN_LEAD_CYCLES  = rtcwd_pkg::WARN_LEAD_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic [14:0] I_ADDR,
  input  wire logic [7:0]  I_DQ,
  input  wire logic        I_CE_B,
  input  wire logic        I_OE_B,
  input  wire logic        I_WE_B,
  output logic [7:0]       O_DQ,
  output logic             O_DQ_OE_B,
  input  wire logic [6:0]  I_CLK_SECONDS,
  input  wire logic [6:0]  I_CLK_MINUTES,
  input  wire logic [5:0]  I_CLK_HOURS,
  input  wire logic [5:0]  I_CLK_DATE,
  input  wire logic        I_SECOND_UPDATE,
  input  wire logic        I_SUPPLY_FAIL,
  input  wire logic        I_BACKUP_MODE,
  input  wire logic        I_BATTERY_LOW,
  output logic             O_INT,
  output logic             O_INT_OE_B,
  output logic             O_RST,
  output logic             O_RST_OE_B,
  output logic             O_SUPPLY_DESELECT
);
  // ---- registers ----
  logic [7:0] flags_r;        // event_flags
  logic [7:0] alm_sec_r;      // alarm_seconds_match
  logic [7:0] alm_min_r;      // alarm_minutes_match
  logic [7:0] alm_hour_r;     // alarm_hours_match
  logic [7:0] alm_date_r;     // alarm_date_match
  logic [7:0] ctrl_r;         // interrupt_control
  logic [7:0] wdog_r;         // watchdog_control
  logic [7:0] wdog_nxt;
  logic [7:0] flags_nxt;

  // ---- watchdog state ----
  rtcwd_pkg::rtcwd_wd_e wd_state_r;
  rtcwd_pkg::rtcwd_wd_e wd_state_nxt;
  logic [10:0] wd_cnt_r;      // elapsed sixteenths of a second
  logic [10:0] wd_cnt_nxt;
  logic [31:0] hold_cnt_r;    // reset pulse length counter
  logic [31:0] hold_cnt_nxt;

  // ---- misc state ----
  logic        first_r;       // high in first cycle after power-up
  logic        fail_q;        // supply fail level one cycle back
  logic [31:0] warn_cnt_r;    // lead time before deselect
  logic        desel_r;       // deselect after warning lead
  logic [11:0] base_cnt_r;    // free count of base ticks
  logic        int_r;         // interrupt pin pulled low
  logic        dq_oe_r;       // data bus driven
  logic        fire_bin;      // binary periodic rate hit

  // ---- bus front end ----
  wire         bus_wr;
  wire  [14:0] bus_wr_addr;
  wire  [7:0]  bus_wr_data;
  wire         bus_rd;
  wire         bus_clr;
  wire         bus_clr_held;

  rtcwd_bus u_bus (
    .i_clk      (I_CLK),
    .i_rst_b    (I_RST_B),
    .i_addr     (I_ADDR),
    .i_dq       (I_DQ),
    .i_ce_b     (I_CE_B),
    .i_oe_b     (I_OE_B),
    .i_we_b     (I_WE_B),
    .o_wr       (bus_wr),
    .o_wr_addr  (bus_wr_addr),
    .o_wr_data  (bus_wr_data),
    .o_rd       (bus_rd),
    .o_clr      (bus_clr),
    .o_clr_held (bus_clr_held)
  );

  // host is cut off while on battery or deselected
  wire bus_ok  = ~I_BACKUP_MODE & ~desel_r;
  wire wr_ok   = bus_wr & bus_ok;
  wire wr_alm0 = wr_ok & (bus_wr_addr == rtcwd_pkg::A_ALM_SEC);
  wire wr_alm1 = wr_ok & (bus_wr_addr == rtcwd_pkg::A_ALM_MIN);
  wire wr_alm2 = wr_ok & (bus_wr_addr == rtcwd_pkg::A_ALM_HOUR);
  wire wr_alm3 = wr_ok & (bus_wr_addr == rtcwd_pkg::A_ALM_DATE);
  wire wr_ctrl = wr_ok & (bus_wr_addr == rtcwd_pkg::A_IRQ_CTRL);
  wire wr_wdog = wr_ok & (bus_wr_addr == rtcwd_pkg::A_WDOG);
  wire clr_ok  = bus_clr & bus_ok;

  // ---- field decode ----
  wire [4:0] wd_mult = wdog_r[rtcwd_pkg::WD_MULT_HI:rtcwd_pkg::WD_MULT_LO];
  wire [1:0] wd_res  = wdog_r[rtcwd_pkg::WD_RES_HI:0];
  wire       wd_steer = wdog_r[rtcwd_pkg::WD_STEER];
  wire [3:0] rate     = ctrl_r[rtcwd_pkg::IC_RATE_HI:0];
  wire       en_alarm = ctrl_r[rtcwd_pkg::IC_ALARM_EN];
  wire       en_sup   = ctrl_r[rtcwd_pkg::IC_SUPPLY_EN];
  wire       en_bkup  = ctrl_r[rtcwd_pkg::IC_BACKUP_EN];
  wire       en_per   = ctrl_r[rtcwd_pkg::IC_PERIOD_EN];

  // resolution scales sixteenths by 1, 4, 16 or 64
  wire [10:0] wd_limit = {6'h00, wd_mult} << {wd_res, 1'b0};

  // ---- time base ----
  wire base_tick;
  wire ms_tick;
  wire tick_16th;
  wire tick_10ms;
  wire tick_100ms;
  // watchdog prescaler restarts with the period
  wire wd_pre_clr = wr_wdog | (wd_state_r != rtcwd_pkg::WD_RUN);

  rtcwd_div #(.N(BASE_TICK_CYCLES)) u_base (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_clr   (1'b0),
    .i_en    (1'b1),
    .o_tick  (base_tick)
  );

  rtcwd_div #(.N(MS_TICK_CYCLES)) u_ms (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_clr   (1'b0),
    .i_en    (1'b1),
    .o_tick  (ms_tick)
  );

  rtcwd_div #(.N(rtcwd_pkg::SIXTEENTH_DIV)) u_16th (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_clr   (wd_pre_clr),
    .i_en    (base_tick),
    .o_tick  (tick_16th)
  );

  rtcwd_div #(.N(rtcwd_pkg::DECADE_DIV)) u_10ms (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_clr   (1'b0),
    .i_en    (ms_tick),
    .o_tick  (tick_10ms)
  );

  rtcwd_div #(.N(rtcwd_pkg::DECADE_DIV)) u_100ms (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_clr   (1'b0),
    .i_en    (tick_10ms),
    .o_tick  (tick_100ms)
  );

  // ---- periodic event ----
  // codes above two: 2^(code-3) base ticks, 122us up to 500ms
  wire [3:0]  bin_shift = rate - rtcwd_pkg::RATE_BIN;
  wire [11:0] bin_mask  = 12'((13'h0001 << bin_shift) - 13'h0001);
  always_comb begin
    fire_bin = base_tick & (rate >= rtcwd_pkg::RATE_BIN) &
               ((base_cnt_r & bin_mask) == bin_mask);
  end
  // code zero matches nothing, so the flag never sets
  wire per_set = fire_bin |
                 (tick_10ms & (rate == rtcwd_pkg::RATE_10MS)) |
                 (tick_100ms & (rate == rtcwd_pkg::RATE_100MS));

  // ---- alarm compare ----
  // a set mask bit drops the field from the match
  wire m_sec  = alm_sec_r[rtcwd_pkg::ALM_MASK] |
                (alm_sec_r[6:0] == I_CLK_SECONDS);
  wire m_min  = alm_min_r[rtcwd_pkg::ALM_MASK] |
                (alm_min_r[6:0] == I_CLK_MINUTES);
  wire m_hour = alm_hour_r[rtcwd_pkg::ALM_MASK] |
                (alm_hour_r[5:0] == I_CLK_HOURS);
  wire m_date = alm_date_r[rtcwd_pkg::ALM_MASK] |
                (alm_date_r[5:0] == I_CLK_DATE);
  wire alm_set = I_SECOND_UPDATE & m_sec & m_min & m_hour & m_date;

  // ---- supply fail ----
  wire fail_rise = I_SUPPLY_FAIL & ~fail_q;

  // ---- watchdog ----
  wire wd_expire = (wd_state_r == rtcwd_pkg::WD_RUN) & ~wr_wdog &
                   tick_16th & (wd_cnt_r + 11'h001 >= wd_limit);
  wire wd_fired  = (wd_state_r == rtcwd_pkg::WD_FIRED);
  wire wd_hold   = (wd_state_r == rtcwd_pkg::WD_HOLD);

  // watchdog sequencing
  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt   = wd_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    case (wd_state_r)
      rtcwd_pkg::WD_OFF: begin
        wd_cnt_nxt = 11'h000;
        // armed by a nonzero multiplier
        if (wd_mult != 5'h00) begin
          wd_state_nxt = rtcwd_pkg::WD_RUN;
        end
      end
      rtcwd_pkg::WD_RUN: begin
        if (wd_mult == 5'h00) begin
          wd_state_nxt = rtcwd_pkg::WD_OFF;
        end else if (wr_wdog) begin
          wd_cnt_nxt = 11'h000;
        end else if (wd_expire) begin
          hold_cnt_nxt = 32'h0000_0000;
          wd_state_nxt = wd_steer ? rtcwd_pkg::WD_HOLD
                                  : rtcwd_pkg::WD_FIRED;
        end else if (tick_16th) begin
          wd_cnt_nxt = wd_cnt_r + 11'h001;
        end
      end
      rtcwd_pkg::WD_HOLD: begin
        hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
        // pulse ends after the hold count
        if (hold_cnt_r == 32'(RESET_HOLD_CYCLES - 1)) begin
          wd_state_nxt = rtcwd_pkg::WD_OFF;
        end
      end
      default: begin
        // interrupt stands until the host rewrites the byte
        if (wr_wdog) begin
          wd_state_nxt = rtcwd_pkg::WD_OFF;
        end
      end
    endcase
    // supply failure overrides everything
    if (fail_rise) begin
      wd_state_nxt = rtcwd_pkg::WD_OFF;
    end
  end

  // watchdog byte: host write, cleared by pulse or failure
  always_comb begin
    wdog_nxt = wdog_r;
    if (wr_wdog) begin
      wdog_nxt = bus_wr_data;
    end
    if (wd_hold || fail_rise) begin
      wdog_nxt = rtcwd_pkg::WDOG_RST;
    end
  end

  // ---- flags: set wins over the read clear ----
  wire [7:0] flag_set = {wd_expire,
                         alm_set,
                         fail_rise,
                         first_r & I_BATTERY_LOW,
                         per_set,
                         3'h0};
  always_comb begin
    flags_nxt = flags_r | flag_set;
    // clear only what the host saw, so a late event survives
    if (clr_ok) begin
      flags_nxt = (flags_r & ~O_DQ) | flag_set;
    end
  end

  // ---- interrupt request ----
  wire int_alarm = flags_r[rtcwd_pkg::FLG_ALARM] & en_alarm;
  wire int_req_on = int_alarm |
                    (flags_r[rtcwd_pkg::FLG_PERIODIC] & en_per) |
                    (flags_r[rtcwd_pkg::FLG_SUPPLY] & en_sup) |
                    wd_fired;
  // on battery only an alarm with backup enable pulls the pin
  wire int_req = I_BACKUP_MODE ? (int_alarm & en_bkup)
                               : int_req_on;

  // ---- read data mux ----
  wire rd_hit = bus_rd & bus_ok & (I_ADDR[14:3] == rtcwd_pkg::A_FLAGS[14:3]) &
                (I_ADDR != rtcwd_pkg::A_FLAGS + 15'h0001);
  wire [7:0] rd_data =
    (I_ADDR == rtcwd_pkg::A_FLAGS)    ? flags_r    :
    (I_ADDR == rtcwd_pkg::A_ALM_SEC)  ? alm_sec_r  :
    (I_ADDR == rtcwd_pkg::A_ALM_MIN)  ? alm_min_r  :
    (I_ADDR == rtcwd_pkg::A_ALM_HOUR) ? alm_hour_r :
    (I_ADDR == rtcwd_pkg::A_ALM_DATE) ? alm_date_r :
    (I_ADDR == rtcwd_pkg::A_IRQ_CTRL) ? ctrl_r     :
    (I_ADDR == rtcwd_pkg::A_WDOG)     ? wdog_r     : 8'h00;

  // open-drain pins: driven value is always low
  assign O_INT      = 1'b0;
  assign O_RST      = 1'b0;
  assign O_INT_OE_B = ~int_r;
  assign O_RST_OE_B = ~wd_hold;
  assign O_DQ_OE_B  = ~dq_oe_r;
  assign O_SUPPLY_DESELECT = desel_r;

  // watchdog and flag registers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      wd_state_r <= rtcwd_pkg::WD_OFF;
      wd_cnt_r   <= 11'h000;
      hold_cnt_r <= 32'h0000_0000;
      wdog_r     <= rtcwd_pkg::WDOG_RST;
      flags_r    <= rtcwd_pkg::FLAGS_RST;
    end else begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r   <= wd_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      wdog_r     <= wdog_nxt;
      flags_r    <= flags_nxt;
    end
  end

  // control and alarm bytes, enables cleared at power-up
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ctrl_r     <= rtcwd_pkg::CTRL_RST;
      alm_sec_r  <= rtcwd_pkg::ALM_RST;
      alm_min_r  <= rtcwd_pkg::ALM_RST;
      alm_hour_r <= rtcwd_pkg::ALM_RST;
      alm_date_r <= rtcwd_pkg::ALM_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= bus_wr_data;
      if (wr_alm0) alm_sec_r <= bus_wr_data;
      if (wr_alm1) alm_min_r <= bus_wr_data;
      if (wr_alm2) alm_hour_r <= bus_wr_data;
      if (wr_alm3) alm_date_r <= bus_wr_data;
    end
  end

  // power-up marker, failure edge, warning lead to deselect
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      first_r    <= 1'b1;
      fail_q     <= 1'b0;
      warn_cnt_r <= 32'h0000_0000;
      desel_r    <= 1'b0;
    end else begin
      first_r <= 1'b0;
      fail_q  <= I_SUPPLY_FAIL;
      if (!I_SUPPLY_FAIL) begin
        warn_cnt_r <= 32'h0000_0000;
        desel_r    <= 1'b0;
      end else if (!desel_r) begin
        warn_cnt_r <= warn_cnt_r + 32'h0000_0001;
        desel_r <= (warn_cnt_r == 32'(WARN_LEAD_CYCLES - 1));
      end
    end
  end

  // periodic counter, pin and read data
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      base_cnt_r <= 12'h000;
      int_r      <= 1'b0;
      dq_oe_r    <= 1'b0;
      O_DQ       <= 8'h00;
    end else begin
      if (base_tick) base_cnt_r <= base_cnt_r + 12'h001;
      int_r   <= int_req;
      dq_oe_r <= rd_hit;
      // read data frozen once the flags clear has taken
      if (!bus_clr && !bus_clr_held) O_DQ <= rd_data;
    end
  end
endmodule

// ---- dv/rtcwd_chk.sv ----
`timescale 1ns/10ps
// pin-level watch on the supervisor top
module rtcwd_chk #(
  parameter int RESET_HOLD_CYCLES = 16
) (
  input  wire logic I_CLK,
  input  wire logic I_RST_B,
  input  wire logic I_SUPPLY_FAIL,
  input  wire logic O_DQ_OE_B,
  input  wire logic O_INT,
  input  wire logic O_INT_OE_B,
  input  wire logic O_RST,
  input  wire logic O_RST_OE_B,
  input  wire logic O_SUPPLY_DESELECT
);
  // cycles the reset pin has been pulled so far
  logic [31:0] hold_cnt_r;
  // restart whenever the pin is released
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B || O_RST_OE_B) begin
      hold_cnt_r <= 32'h0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 32'h1;
    end
  end
  // one domain, so clock and disable are shared
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // open drain: level is only ever low
  AST_RST_OD: assert property (O_RST == 1'b0)
    else $error("reset pin level driven high");
  AST_INT_OD: assert property (O_INT == 1'b0)
    else $error("interrupt pin level driven high");
  // everything released straight out of power-up
  AST_PWRUP: assert property ($rose(I_RST_B) |-> O_RST_OE_B &&
    O_DQ_OE_B && !O_SUPPLY_DESELECT) else $error("pins active at power-up");
  // no enables after power-up, so no interrupt yet
  AST_INIT_QUIET: assert property ($rose(I_RST_B) |-> O_INT_OE_B[*3])
    else $error("interrupt right after power-up");
  // past guard skips a pulse cut short by reset
  AST_RST_LEN: assert property ($rose(O_RST_OE_B) && $past(I_RST_B) |->
    hold_cnt_r == 32'(RESET_HOLD_CYCLES)) else $error("reset pulse length");
  // the byte is cleared, so no pulse follows at once
  AST_RST_ONCE: assert property ($rose(O_RST_OE_B) |-> O_RST_OE_B[*8])
    else $error("second reset pulse too soon");
  // the warning comes before the deselect
  AST_DESEL: assert property ($rose(I_SUPPLY_FAIL) |=>
    !O_SUPPLY_DESELECT[*4]) else $error("deselect without warning lead");
  AST_DESEL_DQ: assert property ($past(O_SUPPLY_DESELECT) |-> O_DQ_OE_B)
    else $error("data driven while deselected");
endmodule

bind rtcwd_top rtcwd_chk #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk_u (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SUPPLY_FAIL(I_SUPPLY_FAIL),
  .O_DQ_OE_B(O_DQ_OE_B), .O_INT(O_INT), .O_INT_OE_B(O_INT_OE_B),
  .O_RST(O_RST), .O_RST_OE_B(O_RST_OE_B),
  .O_SUPPLY_DESELECT(O_SUPPLY_DESELECT));

// ---- dv/rtcwd_host.sv ----
`timescale 1ns/10ps
// host processor: sram-style strobes, one access at a time
module rtcwd_host (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_dq_oe_b,
  output logic [14:0]      o_addr,
  output logic [7:0]       o_dq,
  output logic             o_ce_b,
  output logic             o_oe_b,
  output logic             o_we_b
);
  // idle bus at time zero
  initial begin
    o_addr = 15'h0000;
    o_dq = 8'h00;
    o_ce_b = 1'b1;
    o_oe_b = 1'b1;
    o_we_b = 1'b1;
  end
  // strobe low one cycle, commit on the release edge
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_dq <= d;
    o_ce_b <= 1'b0;
    o_we_b <= 1'b0;
    @(posedge i_clk);
    o_ce_b <= 1'b1;
    o_we_b <= 1'b1;
    // released lines must not keep the old value
    @(posedge i_clk);
    o_addr <= ~a;
    o_dq <= ~d;
    @(posedge i_clk);
  endtask
  // hold sets how long the address stays; clear needs it held
  task automatic rd(input logic [14:0] a, input int hold,
                    output logic [7:0] d, output logic oe);
    @(posedge i_clk);
    o_addr <= a;
    o_ce_b <= 1'b0;
    o_oe_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    d = i_dq;
    oe = i_dq_oe_b;
    repeat (hold) @(posedge i_clk);
    o_ce_b <= 1'b1;
    o_oe_b <= 1'b1;
    o_addr <= ~a;
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
// drives the supervisor through host pins and event inputs
module tb;
  logic        clk;
  logic        rst_b;
  logic        sec_upd;
  logic        sup_fail;
  logic        backup;
  logic        batt_low;
  logic [6:0]  secs;
  logic [6:0]  mins;      // clock minutes seen by the alarm compare
  logic [5:0]  hrs;       // clock hours seen by the alarm compare
  logic [5:0]  date;      // clock date seen by the alarm compare
  logic        int_lvl;   // level the interrupt pin drives when enabled
  logic        rst_lvl;   // level the reset pin drives when enabled
  logic [14:0] addr;
  logic [7:0]  dq_in;
  logic        ce_b;
  logic        oe_b;
  logic        we_b;
  logic [7:0]  dq_out;
  logic        dq_oe_b;
  logic        int_oe_b;
  logic        rst_oe_b;
  logic        desel;
  logic [7:0]  rd_d;
  logic        rd_oe;
  int          mismatches;
  int          n_checks;
  // short counts keep the run small
  rtcwd_top #(.BASE_TICK_CYCLES(4), .MS_TICK_CYCLES(8),
    .RESET_HOLD_CYCLES(16), .WARN_LEAD_CYCLES(8)) dut_u (
    .I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_DQ(dq_in),
    .I_CE_B(ce_b), .I_OE_B(oe_b), .I_WE_B(we_b), .O_DQ(dq_out),
    .O_DQ_OE_B(dq_oe_b), .I_CLK_SECONDS(secs), .I_CLK_MINUTES(mins),
    .I_CLK_HOURS(hrs), .I_CLK_DATE(date), .I_SECOND_UPDATE(sec_upd),
    .I_SUPPLY_FAIL(sup_fail), .I_BACKUP_MODE(backup),
    .I_BATTERY_LOW(batt_low), .O_INT(int_lvl), .O_INT_OE_B(int_oe_b),
    .O_RST(rst_lvl),
    .O_RST_OE_B(rst_oe_b), .O_SUPPLY_DESELECT(desel));
  rtcwd_host host_u (.i_clk(clk), .i_dq(dq_out), .i_dq_oe_b(dq_oe_b),
    .o_addr(addr), .o_dq(dq_in), .o_ce_b(ce_b), .o_oe_b(oe_b),
    .o_we_b(we_b));
  // 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // read must drive, with the expected byte
  task automatic rdchk(input logic [14:0] a, input int hold,
                       input logic [7:0] exp);
    host_u.rd(a, hold, rd_d, rd_oe);
    chk({7'h00, rd_oe}, 8'h00);
    chk(rd_d, exp);
  endtask
  // sel 0 int, 1 reset, 2 deselect; a missed must ends the run
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          input bit must);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk);
      #1;
      hit = ((sel == 0) ? int_oe_b : (sel == 1) ? rst_oe_b : desel) === lvl;
    end
    chk({7'h00, hit}, {7'h00, must});
    if (must && !hit) begin
      wrap_up();
    end
  endtask
  // one once-per-second strobe
  task automatic tick;
    @(posedge clk);
    sec_upd <= 1'b1;
    @(posedge clk);
    sec_upd <= 1'b0;
  endtask
  initial begin
    rst_b = 1'b0;
    sec_upd = 1'b0;
    sup_fail = 1'b0;
    backup = 1'b0;
    batt_low = 1'b1;
    secs = 7'h30;
    mins = 7'h00;
    hrs = 6'h00;
    date = 6'h00;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    batt_low <= 1'b0;
    // weak battery; a short read must not clear it
    rdchk(15'h7ff0, 4, 8'h10);
    rdchk(15'h7ff0, 12, 8'h10);
    rdchk(15'h7ff0, 12, 8'h00);
    host_u.wr(15'h7ff2, 8'ha5);
    rdchk(15'h7ff2, 2, 8'ha5);
    // unmapped hole is not driven
    host_u.rd(15'h7ff1, 2, rd_d, rd_oe);
    chk({7'h00, rd_oe}, 8'h01);
    // fastest periodic rate, with then without its enable
    host_u.wr(15'h7ff6, 8'h13);
    wait_for(0, 1'b0, 20, 1);
    rdchk(15'h7ff0, 12, 8'h08);
    host_u.wr(15'h7ff6, 8'h03);
    rdchk(15'h7ff0, 12, 8'h08);
    wait_for(0, 1'b0, 20, 0);
    host_u.wr(15'h7ff6, 8'h00);
    rdchk(15'h7ff0, 12, 8'h08);
    rdchk(15'h7ff0, 12, 8'h00);
    // alarm on seconds only, then a miss, then a full match
    host_u.wr(15'h7ff2, 8'h30);
    for (int i = 1; i < 4; i++) begin
      host_u.wr(15'h7ff2 + 15'(i), 8'h80);
    end
    host_u.wr(15'h7ff6, 8'h80);
    tick();
    wait_for(0, 1'b0, 8, 1);
    rdchk(15'h7ff0, 12, 8'h40);
    wait_for(0, 1'b1, 4, 1);
    secs <= 7'h31;
    tick();
    rdchk(15'h7ff0, 12, 8'h00);
    secs <= 7'h30;
    for (int i = 1; i < 4; i++) begin
      host_u.wr(15'h7ff2 + 15'(i), 8'h00);
    end
    tick();
    rdchk(15'h7ff0, 12, 8'h40);
    // every second; backup needs its own enable
    host_u.wr(15'h7ff2, 8'hb0);
    backup <= 1'b1;
    tick();
    wait_for(0, 1'b0, 20, 0);
    backup <= 1'b0;
    rdchk(15'h7ff0, 12, 8'h40);
    host_u.wr(15'h7ff6, 8'ha0);
    backup <= 1'b1;
    tick();
    wait_for(0, 1'b0, 20, 1);
    backup <= 1'b0;
    rdchk(15'h7ff0, 12, 8'h40);
    host_u.wr(15'h7ff6, 8'h00);
    // steered to interrupt, restarted three quarters of the way
    host_u.wr(15'h7ff7, 8'h04);
    repeat (1500) @(posedge clk);
    host_u.wr(15'h7ff7, 8'h04);
    wait_for(0, 1'b0, 1500, 0);
    wait_for(0, 1'b0, 1000, 1);
    rdchk(15'h7ff0, 12, 8'h80);
    chk({7'h00, int_oe_b}, 8'h00);
    host_u.wr(15'h7ff7, 8'h00);
    wait_for(0, 1'b1, 4, 1);
    wait_for(0, 1'b0, 2500, 0);
    // quarter-second resolution, steered to reset
    host_u.wr(15'h7ff7, 8'h85);
    wait_for(1, 1'b0, 8000, 0);
    wait_for(1, 1'b0, 400, 1);
    rdchk(15'h7ff7, 2, 8'h00);
    rdchk(15'h7ff0, 12, 8'h80);
    // supply loss: warning, deselect, watchdog dropped
    host_u.wr(15'h7ff6, 8'hf0);
    host_u.wr(15'h7ff7, 8'h84);
    sup_fail <= 1'b1;
    wait_for(0, 1'b0, 8, 1);
    wait_for(2, 1'b1, 20, 1);
    wait_for(1, 1'b0, 2500, 0);
    // power-up again: enables come back clear
    rst_b <= 1'b0;
    sup_fail <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk(15'h7ff6, 2, 8'h00);
    rdchk(15'h7ff0, 12, 8'h00);
    chk({6'h00, int_lvl, rst_lvl}, 8'h00);
    wrap_up();
  end
endmodule
